/* File: rtl/cpc_port_fsm.sv */
/*
  Cable port connection state machines, one per port, with per-port timers.
  Assumes all inputs synchronous to ref_clk; control bits held as levels by the
  register logic outside, requests given as one-cycle pulses.
*/
// Functional notes
// - Power reset puts every port in disconnected.
// - Disable bit set moves any state to disabled.
// - Disconnected: no bias, outputs high impedance; connect detect always works.
// - Disconnected goes to resuming when peer detected attached.
// - Resuming waits five reset-detect intervals alone, two if other ports active.
// - Resuming or suspended losing connection returns to disconnected.
// - Resuming, connected with bias seen, becomes active.
// - Resuming, connected without bias, becomes suspended.
// - Active becomes suspend initiator on suspend-request bit set.
// - Active receiving suspend signal becomes suspend target.
// - Active losing bias goes to suspended.
// - Initiator replies with suspend bit set; other active ports get bus reset.
// - Initiator sends suspend, waits bias low, faults on notify-hold timeout, tri-states.
// - Initiator sends for short-reset, drives bias low bias-hold, faults if bias is back while connected.
// - Target repeats suspend on other active ports, drives bias low.
// - Target waits bias-hold for bias low, faults if bias still seen while connected.
// - Initiator and target always finish in suspended.
// - Unfaulted suspended port resumes on resume bit, resume packet or bias.
// - Faulted suspended port stays, clears fault when bias goes away.
// - Disable cleared: disconnected if unattached, else suspended.
// - Entering resuming: clear timer, drive bias, mark other ports resume.
// - Resuming, suspended, disabled report interrupt or link-on to link.
module cpc_port_fsm import cpc_pkg::*; #(
  parameter int unsigned PORT_COUNT = PORT_COUNT_DEF
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic [PORT_COUNT-1:0] connect_detect,
  input  wire logic [PORT_COUNT-1:0] bias_detect,
  input  wire logic [PORT_COUNT-1:0] rx_suspend,
  input  wire logic [PORT_COUNT-1:0] port_disable,
  input  wire logic [PORT_COUNT-1:0] suspend_req,
  input  wire logic [PORT_COUNT-1:0] resume_req,
  input  wire logic [PORT_COUNT-1:0] resume_pkt,
  input  wire logic [PORT_COUNT-1:0] int_enable,
  input  wire logic                  link_powered,
  input  wire logic                  wakeup,
  output logic [PORT_COUNT-1:0]      port_active,
  output logic [PORT_COUNT-1:0]      port_fault,
  output logic [PORT_COUNT-1:0]      bias_out,
  output logic [PORT_COUNT-1:0]      bias_oe_n,
  output logic [PORT_COUNT-1:0]      tx_suspend,
  output logic [PORT_COUNT-1:0]      tx_suspend_repeat,
  output logic [PORT_COUNT-1:0]      line_oe_n,
  output logic [PORT_COUNT-1:0]      suspend_reply,
  output logic [PORT_COUNT-1:0]      bus_reset_req,
  output logic [PORT_COUNT-1:0]      resume_mark,
  output logic [PORT_COUNT-1:0]      int_event,
  output logic [PORT_COUNT-1:0]      link_on_event
);
  localparam logic [TIMER_W-1:0] T_RDET  = TIMER_W'(RESET_DETECT_CYC);
  localparam logic [TIMER_W-1:0] T_DMIN  = TIMER_W'(DETECT_MIN_CYC);
  localparam logic [TIMER_W-1:0] T_SHORT = TIMER_W'(SHORT_RESET_CYC);
  localparam logic [TIMER_W-1:0] T_NOTE  = TIMER_W'(NOTIFY_HOLD_CYC);
  localparam logic [TIMER_W-1:0] T_BHOLD = TIMER_W'(BIAS_HOLD_CYC);
  localparam logic [TIMER_W-1:0] T_WAIT5 = TIMER_W'(RESUME_WAIT_ALONE * RESET_DETECT_CYC);
  localparam logic [TIMER_W-1:0] T_WAIT2 = TIMER_W'(RESUME_WAIT_BNODE * RESET_DETECT_CYC);

  logic [PORT_COUNT-1:0] act_vec;
  logic [PORT_COUNT-1:0] entering_resume;
  logic [PORT_COUNT-1:0] sus_entry;
  logic [PORT_COUNT-1:0] tgt_vec;

  assign port_active = act_vec;

  genvar gi;
  generate
    for (gi = 0; gi < PORT_COUNT; gi++) begin : g_port
      cpc_state_t       state_reg;
      cpc_state_t       state_next;
      logic             fault_reg;
      logic             fault_next;
      logic             bias_drv_reg;
      logic             bias_drv_next;
      logic             bias_val_reg;
      logic             bias_val_next;
      logic             txs_reg;
      logic             txs_next;
      logic             clr;
      logic             others_active;
      logic             others_target;
      logic             report;
      logic [TIMER_W-1:0] tmr;
      logic [TIMER_W-1:0] wait_lim;

      cpc_timer #(.WIDTH(TIMER_W)) u_timer (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clear   (clr),
        .count   (tmr)
      );

      always_comb begin
        others_active = |(act_vec & ~(PORT_COUNT'(1) << gi));
        others_target = |(tgt_vec & ~(PORT_COUNT'(1) << gi));
        wait_lim      = others_active ? T_WAIT2 : T_WAIT5;
        state_next    = state_reg;
        fault_next    = fault_reg;
        bias_drv_next = bias_drv_reg;
        bias_val_next = bias_val_reg;
        txs_next      = 1'b0;
        clr           = 1'b0;
        if (port_disable[gi]) begin
          state_next    = CPC_DISABLED;
          bias_drv_next = 1'b0;
        end else begin
          case (state_reg)
            CPC_DISCONNECTED: begin
              bias_drv_next = 1'b0;
              if (connect_detect[gi]) begin
                state_next    = CPC_RESUMING;
                clr           = 1'b1;
                bias_drv_next = 1'b1;
                bias_val_next = 1'b1;
              end
            end
            CPC_RESUMING: begin
              if (fault_reg && (bias_detect[gi] || tmr >= T_DMIN)) begin
                bias_drv_next = 1'b0;
              end
              if (!connect_detect[gi]) begin
                state_next    = CPC_DISCONNECTED;
                bias_drv_next = 1'b0;
              end else if (tmr >= wait_lim && tmr >= T_DMIN) begin
                if (bias_detect[gi]) begin
                  state_next = CPC_ACTIVE;
                end else begin
                  state_next    = CPC_SUSPENDED;
                  bias_drv_next = 1'b0;
                end
              end
            end
            CPC_ACTIVE: begin
              if (suspend_req[gi]) begin
                state_next = CPC_INIT_SEND;
                clr        = 1'b1;
              end else if (rx_suspend[gi]) begin
                state_next    = CPC_TARGET;
                clr           = 1'b1;
                bias_drv_next = 1'b1;
                bias_val_next = 1'b0;
              end else if (!bias_detect[gi]) begin
                state_next    = CPC_SUSPENDED;
                bias_drv_next = 1'b0;
              end
            end
            CPC_INIT_SEND: begin
              txs_next = tmr < T_SHORT;
              if (tmr >= T_SHORT) begin
                state_next = CPC_INIT_WAIT;
              end
            end
            CPC_INIT_WAIT: begin
              if (!bias_detect[gi]) begin
                state_next    = CPC_INIT_HOLD;
                clr           = 1'b1;
                bias_val_next = 1'b0;
              end else if (tmr >= T_NOTE) begin
                state_next    = CPC_SUSPENDED;
                bias_drv_next = 1'b0;
                fault_next    = connect_detect[gi];
              end
            end
            CPC_INIT_HOLD: begin
              if (tmr >= T_BHOLD) begin
                state_next    = CPC_SUSPENDED;
                bias_drv_next = 1'b0;
                fault_next    = bias_detect[gi] && connect_detect[gi];
              end
            end
            CPC_TARGET: begin
              if (!bias_detect[gi] || tmr >= T_BHOLD) begin
                state_next    = CPC_SUSPENDED;
                bias_drv_next = 1'b0;
                fault_next    = bias_detect[gi] && connect_detect[gi];
              end
            end
            CPC_SUSPENDED: begin
              if (!connect_detect[gi]) begin
                state_next = CPC_DISCONNECTED;
                fault_next = 1'b0;
              end else if (fault_reg) begin
                if (!bias_detect[gi]) begin
                  fault_next = 1'b0;
                end
              end else if (resume_req[gi] || resume_pkt[gi] || bias_detect[gi]) begin
                state_next    = CPC_RESUMING;
                clr           = 1'b1;
                bias_drv_next = 1'b1;
                bias_val_next = 1'b1;
              end
            end
            CPC_DISABLED: begin
              bias_drv_next = 1'b0;
              fault_next    = fault_reg && bias_detect[gi];
              state_next    = connect_detect[gi] ? CPC_SUSPENDED : CPC_DISCONNECTED;
            end
            default: begin
              state_next = CPC_DISCONNECTED;
            end
          endcase
        end
      end

      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          state_reg    <= CPC_DISCONNECTED;
          fault_reg    <= 1'b0;
          bias_drv_reg <= 1'b0;
          bias_val_reg <= 1'b0;
          txs_reg      <= 1'b0;
        end else begin
          state_reg    <= state_next;
          fault_reg    <= fault_next;
          bias_drv_reg <= bias_drv_next;
          bias_val_reg <= bias_val_next;
          txs_reg      <= txs_next;
        end
      end

      always_comb begin
        act_vec[gi]         = state_reg == CPC_ACTIVE;
        tgt_vec[gi]         = state_reg == CPC_TARGET;
        sus_entry[gi]       = state_reg == CPC_ACTIVE && state_next == CPC_INIT_SEND;
        entering_resume[gi] = state_reg != CPC_RESUMING && state_next == CPC_RESUMING;
        report = state_reg == CPC_RESUMING || state_reg == CPC_SUSPENDED || state_reg == CPC_DISABLED;
      end

      assign port_fault[gi]        = fault_reg;
      assign bias_out[gi]          = bias_val_reg;
      assign bias_oe_n[gi]         = !bias_drv_reg;
      assign tx_suspend[gi]        = txs_reg;
      assign line_oe_n[gi]         = !(state_reg == CPC_ACTIVE || state_reg == CPC_INIT_SEND);
      assign tx_suspend_repeat[gi] = act_vec[gi] && others_target;
      assign suspend_reply[gi]     = sus_entry[gi];
      assign bus_reset_req[gi]     = act_vec[gi] && |(sus_entry & ~(PORT_COUNT'(1) << gi));
      assign resume_mark[gi]       = |(entering_resume & ~(PORT_COUNT'(1) << gi));

      cpc_event u_event (
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .report_en     (report),
        .int_enable    (int_enable[gi]),
        .link_powered  (link_powered),
        .wakeup        (wakeup),
        .int_event     (int_event[gi]),
        .link_on_event (link_on_event[gi])
      );
    end
  endgenerate
endmodule // cpc_port_fsm

/* File: rtl/cpc_pkg.sv */
/*
  Package for the per-port cable connection state machine.
  Assumes a single 10 MHz clock; all times are counted in cycles of it.
*/
package cpc_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  // Times in microseconds
  localparam int unsigned RESET_DETECT_US    = 1;
  localparam int unsigned DETECT_MIN_US      = 2;
  localparam int unsigned SHORT_RESET_US     = 2;
  localparam int unsigned NOTIFY_HOLD_US     = 4;
  localparam int unsigned BIAS_HOLD_US       = 3;
  // Least times, rounded up to whole cycles
  localparam int unsigned RESET_DETECT_CYC = (RESET_DETECT_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned DETECT_MIN_CYC   = (DETECT_MIN_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned SHORT_RESET_CYC  = (SHORT_RESET_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned NOTIFY_HOLD_CYC  = (NOTIFY_HOLD_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned BIAS_HOLD_CYC    = (BIAS_HOLD_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned RESUME_WAIT_ALONE = 5;
  localparam int unsigned RESUME_WAIT_BNODE = 2;
  localparam int unsigned TIMER_W           = 16;
  localparam int unsigned PORT_COUNT_DEF    = 3;

  typedef enum logic [3:0] {
    CPC_DISCONNECTED,
    CPC_RESUMING,
    CPC_ACTIVE,
    CPC_INIT_SEND,
    CPC_INIT_WAIT,
    CPC_INIT_HOLD,
    CPC_TARGET,
    CPC_SUSPENDED,
    CPC_DISABLED
  } cpc_state_t;
endpackage

/* File: rtl/cpc_timer.sv */
/*
  Per-port connection timer: counts ref_clk cycles, cleared on demand, saturates.
  Assumes one clock domain.
*/
module cpc_timer import cpc_pkg::*; #(
  parameter int unsigned WIDTH = TIMER_W
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             clear,
  output logic [WIDTH-1:0]      count
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (clear) begin
      count_next = '0;
    end else if (count_reg != {WIDTH{1'b1}}) begin
      count_next = count_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;
endmodule // cpc_timer

/* File: rtl/cpc_event.sv */
/*
  Event reporting toward the link for one port: interrupt or link-on level, held while reporting.
  Assumes link status inputs synchronous to ref_clk.
*/
module cpc_event import cpc_pkg::*; (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic report_en,
  input  wire logic int_enable,
  input  wire logic link_powered,
  input  wire logic wakeup,
  output logic      int_event,
  output logic      link_on_event
);
  logic int_reg;
  logic int_next;
  logic lon_reg;
  logic lon_next;
  logic link_up;

  always_comb begin
    link_up  = link_powered;
    int_next = 1'b0;
    lon_next = 1'b0;
    if (report_en) begin
      if (int_enable && link_up) begin
        int_next = 1'b1;
      end else if (!link_up && wakeup) begin
        lon_next = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_reg <= 1'b0;
      lon_reg <= 1'b0;
    end else begin
      int_reg <= int_next;
      lon_reg <= lon_next;
    end
  end

  assign int_event     = int_reg;
  assign link_on_event = lon_reg;
endmodule // cpc_event

/* File: verif/cpc_port_fsm_monitor.sv */
/* Checker on the ports of cpc_port_fsm, bound after the module.
   Assumes PORT_COUNT of three or more and the package timing. */
module cpc_port_fsm_monitor import cpc_pkg::*; #(
  parameter int unsigned PORT_COUNT = PORT_COUNT_DEF
) (
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  input wire logic [PORT_COUNT-1:0] bias_detect,
  input wire logic [PORT_COUNT-1:0] rx_suspend,
  input wire logic [PORT_COUNT-1:0] port_disable,
  input wire logic [PORT_COUNT-1:0] suspend_req,
  input wire logic [PORT_COUNT-1:0] int_enable,
  input wire logic                  link_powered,
  input wire logic [PORT_COUNT-1:0] port_active,
  input wire logic [PORT_COUNT-1:0] port_fault,
  input wire logic [PORT_COUNT-1:0] bias_out,
  input wire logic [PORT_COUNT-1:0] bias_oe_n,
  input wire logic [PORT_COUNT-1:0] tx_suspend,
  input wire logic [PORT_COUNT-1:0] tx_suspend_repeat,
  input wire logic [PORT_COUNT-1:0] suspend_reply,
  input wire logic [PORT_COUNT-1:0] bus_reset_req,
  input wire logic [PORT_COUNT-1:0] resume_mark,
  input wire logic [PORT_COUNT-1:0] int_event
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] wait_reg;
  logic [7:0] wait_next;
  // Cycles spent driving bias high while not active
  always_comb wait_next = (bias_out[0] && !bias_oe_n[0] && !port_active[0]) ?
                          ((wait_reg == 8'hff) ? wait_reg : wait_reg + 8'h01) : 8'h00;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) wait_reg <= 8'h00;
    else wait_reg <= wait_next;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_reset_idle: assert property ($rose(rst_n) |-> !port_active[0] && bias_oe_n[0])
    else $error("port not idle after reset");
  a_reply_active: assert property (suspend_req[0] && !port_disable[0] |-> suspend_reply[0] == port_active[0])
    else $error("suspend reply does not follow active state");
  a_reset_others: assert property (suspend_reply[0] |-> bus_reset_req[2:1] == port_active[2:1])
    else $error("bus reset not raised on other active ports");
  a_send_short: assert property ($rose(tx_suspend[0]) |-> tx_suspend[0] [*8] ##13 !tx_suspend[0])
    else $error("suspend signal length wrong");
  a_bias_loss: assert property (port_active[0] && !bias_detect[0] && !port_disable[0] && !rx_suspend[0]
    && !suspend_req[0] |=> !port_active[0])
    else $error("active port kept without bias");
  a_target_ack: assert property (port_active[0] && rx_suspend[0] && bias_detect[0] && !port_disable[0]
    && !suspend_req[0] |=> !bias_out[0] && !bias_oe_n[0] && tx_suspend_repeat[1] == port_active[1])
    else $error("target did not drive bias low or repeat");
  a_resume_mark: assert property ($rose(bias_out[0] && !bias_oe_n[0]) |-> $past(resume_mark[1]) && $past(resume_mark[2]))
    else $error("other ports not marked on resume");
  a_resume_wait: assert property ($rose(port_active[0]) && port_active[2:1] == 2'h0 |-> wait_reg >= 8'h32)
    else $error("resume wait too short");
  a_event_int: assert property ((port_disable[0] && link_powered && int_enable[0]) [*3] |-> int_event[0])
    else $error("interrupt event missing");
  a_fault_hold: assert property (port_fault[0] && !port_disable[0] |=> bias_oe_n[0])
    else $error("faulted port drives bias");
  a_fault_clear: assert property (port_fault[0] && !bias_detect[0] && !port_disable[0] |=> !port_fault[0])
    else $error("fault not cleared after bias removal");
endmodule // cpc_port_fsm_monitor

bind cpc_port_fsm cpc_port_fsm_monitor #(.PORT_COUNT(PORT_COUNT)) u_cpc_port_fsm_monitor (
  .ref_clk(ref_clk), .rst_n(rst_n), .bias_detect(bias_detect), .rx_suspend(rx_suspend),
  .port_disable(port_disable), .suspend_req(suspend_req), .int_enable(int_enable), .link_powered(link_powered),
  .port_active(port_active), .port_fault(port_fault), .bias_out(bias_out), .bias_oe_n(bias_oe_n),
  .tx_suspend(tx_suspend), .tx_suspend_repeat(tx_suspend_repeat), .suspend_reply(suspend_reply),
  .bus_reset_req(bus_reset_req), .resume_mark(resume_mark), .int_event(int_event)
);

/* File: verif/cpc_peer_model.sv */
/* Peer cable ports: attach, bias and suspend replies per port.
   Assumes the bench commands attach, bias and cooperation levels. */
module cpc_peer_model import cpc_pkg::*; #(
  parameter int unsigned N = PORT_COUNT_DEF
) (
  input wire logic         ref_clk,
  input wire logic         rst_n,
  input wire logic [N-1:0] attached,
  input wire logic [N-1:0] bias_on,
  input wire logic [N-1:0] coop,
  input wire logic [N-1:0] tx_suspend,
  input wire logic [N-1:0] bias_out,
  input wire logic [N-1:0] bias_oe_n,
  output logic [N-1:0]     connect_detect,
  output logic [N-1:0]     bias_detect
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [N-1:0] drop_reg;
  logic [N-1:0] drop_next;
  // Pull own bias low on suspend or on bias driven low
  always_comb drop_next = (drop_reg | (coop & attached & (tx_suspend | (~bias_oe_n & ~bias_out)))) & bias_on;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) drop_reg <= '0;
    else drop_reg <= drop_next;
  end
  assign connect_detect = attached;
  assign bias_detect    = attached & bias_on & ~drop_reg;
endmodule // cpc_peer_model

/* File: verif/cable_port_connection_fsm_bench.sv */
/* Bench for cpc_port_fsm with peer model; scenarios on port zero.
   Assumes the package timing and three ports. */
module cable_port_connection_fsm_bench import cpc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk, rst_n, link_powered, wakeup;
  logic [2:0] att, bon, coop, rx_suspend, port_disable, suspend_req, resume_req, resume_pkt, int_enable;
  logic [2:0] connect_detect, bias_detect, port_active, port_fault, bias_out, bias_oe_n, tx_suspend;
  logic [2:0] tx_suspend_repeat, line_oe_n, suspend_reply, bus_reset_req, resume_mark, int_event, link_on_event;
  int         bad_count, samples_checked, n;
  cpc_port_fsm #(.PORT_COUNT(3)) u_cpc_port_fsm (.ref_clk(ref_clk), .rst_n(rst_n),
    .connect_detect(connect_detect), .bias_detect(bias_detect), .rx_suspend(rx_suspend),
    .port_disable(port_disable), .suspend_req(suspend_req), .resume_req(resume_req), .resume_pkt(resume_pkt),
    .int_enable(int_enable), .link_powered(link_powered), .wakeup(wakeup), .port_active(port_active),
    .port_fault(port_fault), .bias_out(bias_out), .bias_oe_n(bias_oe_n), .tx_suspend(tx_suspend),
    .tx_suspend_repeat(tx_suspend_repeat), .line_oe_n(line_oe_n), .suspend_reply(suspend_reply),
    .bus_reset_req(bus_reset_req), .resume_mark(resume_mark), .int_event(int_event), .link_on_event(link_on_event));
  cpc_peer_model #(.N(3)) u_cpc_peer_model (.ref_clk(ref_clk), .rst_n(rst_n), .attached(att), .bias_on(bon),
    .coop(coop), .tx_suspend(tx_suspend), .bias_out(bias_out), .bias_oe_n(bias_oe_n),
    .connect_detect(connect_detect), .bias_detect(bias_detect));
  task automatic step(input int k);
    repeat (k) begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  task automatic chk(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t ns: check %0d", $time, samples_checked);
    end
  endtask
  // Wait on active, bias release or suspend signal, counting edges
  task automatic wt(input int sel, input logic v);
    for (n = 0; n < 300; n++) begin
      if ((sel == 0 ? port_active[0] : sel == 1 ? bias_oe_n[0] : tx_suspend[0]) === v) break;
      step(1);
    end
    if (n == 300) chk(1'b0, 1'b1);
  endtask
  task automatic pulse_req(input int sel);
    if (sel == 0) suspend_req[0] = 1'b1;
    else if (sel == 1) resume_req[0] = 1'b1;
    else resume_pkt[0] = 1'b1;
    #1 chk(suspend_reply[0], sel == 0);
    chk(bus_reset_req[1], sel == 0);
    step(1);
    {suspend_req[0], resume_req[0], resume_pkt[0]} = 3'h0;
  endtask
  task automatic t_connect();
    chk(bias_oe_n[0] & line_oe_n[0] & ~port_active[0], 1'b1);
    bon[0] = 1'b1;
    att[0] = 1'b1;
    #1 chk(resume_mark[1], 1'b1);
    step(1);
    chk(bias_out[0] & ~bias_oe_n[0], 1'b1);
    wt(0, 1'b1);
    chk(n >= RESUME_WAIT_ALONE * RESET_DETECT_CYC, 1'b1);
  endtask
  task automatic t_bias_loss();
    bon[0] = 1'b0;
    step(1);
    chk(port_active[0], 1'b0);
    step(2);
    bon[0] = 1'b1;
    step(2);
    chk(bias_out[0] & ~bias_oe_n[0], 1'b1);
    wt(0, 1'b1);
  endtask
  task automatic t_init_ok();
    att[1] = 1'b1;
    bon[1] = 1'b1;
    step(RESUME_WAIT_ALONE * RESET_DETECT_CYC);
    chk(port_active[1], 1'b1);
    pulse_req(0);
    chk(port_active[0], 1'b0);
    step(1);
    chk(tx_suspend[0], 1'b1);
    wt(2, 1'b0);
    chk(n == SHORT_RESET_CYC, 1'b1);
    step(2);
    chk(bias_out[0] | bias_oe_n[0], 1'b0);
    wt(1, 1'b1);
    chk(port_fault[0], 1'b0);
    bon[0] = 1'b0;
    step(2);
    pulse_req(2);
    chk(bias_out[0] & ~bias_oe_n[0], 1'b1);
    bon[0] = 1'b1;
    wt(0, 1'b1);
    chk(n < RESUME_WAIT_ALONE * RESET_DETECT_CYC, 1'b1);
  endtask
  task automatic t_init_fault();
    coop[0] = 1'b0;
    pulse_req(0);
    wt(2, 1'b0);
    wt(1, 1'b1);
    chk(port_fault[0], 1'b1);
    pulse_req(1);
    step(1);
    chk(bias_oe_n[0], 1'b1);
    bon[0] = 1'b0;
    step(2);
    chk(port_fault[0], 1'b0);
    coop[0] = 1'b1;
    pulse_req(1);
    chk(bias_out[0] & ~bias_oe_n[0], 1'b1);
    bon[0] = 1'b1;
    wt(0, 1'b1);
  endtask
  task automatic t_disable();
    int_enable[0] = 1'b1;
    link_powered = 1'b1;
    port_disable[0] = 1'b1;
    step(1);
    chk(port_active[0], 1'b0);
    step(2);
    chk(int_event[0] & ~link_on_event[0], 1'b1);
    link_powered = 1'b0;
    wakeup = 1'b1;
    bon[0] = 1'b0;
    step(2);
    chk(link_on_event[0] & ~int_event[0], 1'b1);
    port_disable[0] = 1'b0;
    step(3);
    chk(bias_oe_n[0], 1'b1);
    port_disable[0] = 1'b1;
    att[0] = 1'b0;
    step(1);
    port_disable[0] = 1'b0;
    step(1);
    att[0] = 1'b1;
    step(2);
    chk(bias_out[0] & ~bias_oe_n[0], 1'b1);
    wt(1, 1'b1);
    chk(port_active[0], 1'b0);
    att[0] = 1'b0;
    step(2);
    att[0] = 1'b1;
    step(2);
    chk(bias_out[0] & ~bias_oe_n[0], 1'b1);
    bon[0] = 1'b1;
    wt(0, 1'b1);
  endtask
  task automatic t_target();
    rx_suspend[0] = 1'b1;
    step(1);
    rx_suspend[0] = 1'b0;
    chk(bias_out[0] | bias_oe_n[0] | port_active[0], 1'b0);
    chk(tx_suspend_repeat[1], 1'b1);
    wt(1, 1'b1);
    chk(n < BIAS_HOLD_CYC && port_fault[0] === 1'b0, 1'b1);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    {att, bon, rx_suspend, port_disable, suspend_req, resume_req, resume_pkt, int_enable} = '0;
    coop = 3'h7;
    link_powered = 1'b0;
    wakeup = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    step(2);
    rst_n = 1'b1;
    t_connect();
    t_bias_loss();
    t_init_ok();
    t_init_fault();
    t_disable();
    t_target();
    tally_and_finish();
  end
endmodule // cable_port_connection_fsm_bench
